// >>> src/irp_set0_regs.sv
// Functional notes
// - Eight sets share one window; set select in every set.
// - Offset 2: status or FIFO control; offset 3: control or set select.
// - Offset 0 reads receive data, writes transmit data, one byte per access.
// - Legacy is programmed I/O only; fast and remote modes add DMA.
// - Two DMA channels; swap or receive-only gives one shared channel.
// - Enable bit 3 reads zero; in legacy bits 7..4 too.
// - Advanced enables 7..4: timer, frame status, transmit threshold, DMA.
// - Enable bit 2 line status/frame end, 1 transmit empty, 0 receive.
// - Legacy status bits 7..6 show FIFO mode; bits 5..4 read zero.
// - Legacy status bit 0 is one while nothing enabled pends.
// - Four character times unread in FIFO mode give time-out; read clears.
// - Receive ready second; clears on read or below trigger level.
// - Transmit empty third; buffer write or status read when top clears.
// - Timer flag sets at count zero when loaded, running and enabled.
// - Frame status flag follows its FIFO threshold, fast modes only.
// - Transmit threshold flag is one while below threshold.
// - DMA flag sets on terminal count in fast or remote; status read clears.
// - Handshake flag sets on enabled toggle; handshake status read clears.
// - Status bit 2: line errors in serial modes, frame end in fast modes.
// - Idle flag sets when queue and shifter empty; status read clears.
// - Receive threshold flag: level reached or time-out.
// - FIFO control bit 0 enables FIFO mode, gating the other bits.
`timescale 1ns/10ps
`default_nettype none
module irp_set0_regs
    import irp_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    input wire irp_evt_t evt_in,
    input wire irp_path_t path_in,
    input wire irp_cfg_t cfg_in,
    output logic [7:0] tx_data_out,
    output logic tx_write_out,
    output logic rx_read_out,
    output logic line_status_read_out,
    output logic hs_status_read_out,
    output logic rx_fifo_reset_out,
    output logic tx_fifo_reset_out,
    output logic [2:0] active_set_out,
    output logic [7:0] ir_control_out,
    output logic [7:0] hs_control_out,
    output logic fifo_mode_out,
    output logic dma_allowed_out,
    output logic dma_single_out,
    output logic irq_out
);

    logic [7:0] ien_r;
    logic [7:0] fifo_ctrl_r;
    logic [7:0] set_select_r;
    logic [7:0] ir_control_r;
    logic [7:0] hs_control_r;
    logic [7:0] scratch_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [7:0] tx_data_r;
    logic tx_write_r;
    logic rx_read_r;
    logic line_rd_r;
    logic hs_rd_r;
    logic rx_rst_r;
    logic tx_rst_r;
    logic line_err_r;
    logic thre_r;
    logic timer_flag_r;
    logic dma_flag_r;
    logic hs_flag_r;
    logic fend_r;
    logic tx_idle_r;
    logic tx_empty_q;
    logic tx_idle_q;
    logic [2:0] char_cnt_r;
    logic timeout_r;
    logic irq_r;
    logic [2:0] active_set_r;
    logic dma_allowed_r;
    logic dma_single_r;

    // Bus decode
    wire [2:0] idx = paddr_in[4:2];
    wire addr_bad = (paddr_in[11:5] != 7'h00) || (paddr_in[1:0] != 2'h0);
    wire setup = psel_in && !penable_in;
    wire access = psel_in && penable_in && pready_r;
    wire wr_ok = access && pwrite_in && !pslverr_r;
    wire rd_ok = access && !pwrite_in && !pslverr_r;
    wire in_set0 = !set_select_r[IRP_SET_HIGH_BIT];
    wire [7:0] wbyte = pwdata_in[7:0];
    wire wr_buf = wr_ok && in_set0 && idx == IRP_IDX_BUFFER;
    wire wr_ien = wr_ok && in_set0 && idx == IRP_IDX_IRQ_ENABLE;
    wire wr_fifo = wr_ok && in_set0 && idx == IRP_IDX_STATUS_FIFO;
    wire wr_sel = wr_ok && idx == IRP_IDX_SET_SELECT;
    wire wr_hsc = wr_ok && in_set0 && idx == IRP_IDX_HS_CONTROL;
    wire wr_scr = wr_ok && in_set0 && idx == IRP_IDX_SCRATCH;
    wire rd_buf = rd_ok && in_set0 && idx == IRP_IDX_BUFFER;
    wire rd_status = rd_ok && in_set0 && idx == IRP_IDX_STATUS_FIFO;
    wire rd_line = rd_ok && in_set0 && idx == IRP_IDX_LINE_STATUS;
    wire rd_hs = rd_ok && in_set0 && idx == IRP_IDX_HS_STATUS;

    // Unlisted codes with bit 7 set mean set 1
    wire [2:0] set_nxt;
    assign set_nxt = !set_select_r[IRP_SET_HIGH_BIT] ? 3'd0 :
                     set_select_r == IRP_SEL_SET2 ? 3'd2 :
                     set_select_r == IRP_SEL_SET3 ? 3'd3 :
                     set_select_r == IRP_SEL_SET4 ? 3'd4 :
                     set_select_r == IRP_SEL_SET5 ? 3'd5 :
                     set_select_r == IRP_SEL_SET6 ? 3'd6 :
                     set_select_r == IRP_SEL_SET7 ? 3'd7 : 3'd1;
    wire ctrl_set = set_nxt == 3'd0 || set_nxt == 3'd1;

    // Mode classes
    wire adv = cfg_in.adv_mode;
    wire [2:0] sub = hs_control_r[7:5];
    wire fast = adv && (sub == IRP_MODE_MIR_LOW || sub == IRP_MODE_MIR_HIGH
                        || sub == IRP_MODE_FIR);
    wire remote = adv && sub == IRP_MODE_REMOTE;
    wire serial_adv = adv && !fast && !remote;
    wire fifo_en = fifo_ctrl_r[IRP_FIFO_EN_BIT];

    // Thresholds
    wire [1:0] rx_sel = fifo_ctrl_r[7:6];
    wire [1:0] tx_sel = fifo_ctrl_r[5:4];
    wire [5:0] rx_thr = path_in.fifo32 ? IRP_RX_THR_32[rx_sel] : IRP_RX_THR_16[rx_sel];
    wire [5:0] tx_thr = path_in.fifo32 ? IRP_TX_THR_32[tx_sel] : IRP_TX_THR_16[tx_sel];
    wire rx_at_thr = path_in.rx_level >= rx_thr;
    wire rx_has = path_in.rx_level != 6'd0;
    wire tx_empty = path_in.tx_level == 6'd0;
    wire tx_idle = tx_empty && evt_in.tx_shift_empty;

    // Level flags
    wire rx_ready = fifo_en ? rx_at_thr : rx_has;
    wire rx_thr_flag = rx_at_thr || timeout_r;
    wire tx_thr_flag = path_in.tx_level < tx_thr;
    wire fsf_flag = fast && evt_in.fsf_at_threshold;
    wire bit2_flag = fast ? fend_r : serial_adv && line_err_r;

    // Legacy priority encode over enabled sources
    wire lg_line = ien_r[2] && line_err_r;
    wire lg_tout = ien_r[0] && fifo_en && timeout_r;
    wire lg_rx = ien_r[0] && rx_ready;
    wire lg_thre = ien_r[1] && thre_r;
    wire [3:0] lg_id = lg_line ? IRP_ID_LINE :
                       lg_tout ? IRP_ID_TIMEOUT :
                       lg_rx ? IRP_ID_RX :
                       lg_thre ? IRP_ID_TX_EMPTY :
                       IRP_ID_NONE;
    wire [7:0] lg_status = {fifo_en, fifo_en, 2'b00, lg_id};
    wire thre_top = !adv && lg_id == IRP_ID_TX_EMPTY;

    wire [7:0] adv_status = {timer_flag_r, fsf_flag, tx_thr_flag, dma_flag_r,
                             hs_flag_r, bit2_flag, tx_idle_r, rx_thr_flag};
    wire [7:0] status = adv ? adv_status : lg_status;
    wire [7:0] ien_view = ien_r & (adv ? IRP_IEN_ADV_MASK : IRP_IEN_LEGACY_MASK);

    // Bit 3 has no enable; gated at its set
    wire [7:0] adv_gate = {ien_r[7], ien_r[6] && fast, ien_r[5], ien_r[4], 1'b1,
                           ien_r[2], ien_r[1], ien_r[0]};
    wire irq_nxt = adv ? |(adv_status & adv_gate) : lg_id != IRP_ID_NONE;

    wire [7:0] rd_byte;
    assign rd_byte = !in_set0 ? (idx == IRP_IDX_SET_SELECT ? set_select_r : 8'h00) :
                     idx == IRP_IDX_BUFFER ? path_in.rx_data :
                     idx == IRP_IDX_IRQ_ENABLE ? ien_view :
                     idx == IRP_IDX_STATUS_FIFO ? status :
                     idx == IRP_IDX_SET_SELECT ? set_select_r :
                     idx == IRP_IDX_HS_CONTROL ? hs_control_r :
                     idx == IRP_IDX_LINE_STATUS ? path_in.line_status :
                     idx == IRP_IDX_HS_STATUS ? path_in.handshake_status :
                     scratch_r;

    // FIFO control write; other bits only land with FIFO mode on
    wire fifo_on_nxt = wbyte[IRP_FIFO_EN_BIT];
    wire [7:0] fifo_ctrl_nxt = fifo_on_nxt ? {wbyte[7:4], 3'b000, 1'b1} :
                               {fifo_ctrl_r[7:4], 4'h0};

    // A set coinciding with its clear wins
    wire line_set = evt_in.line_error;
    wire timer_set = adv && evt_in.timer_zero && evt_in.timer_loaded
                     && evt_in.timer_run && ien_r[7];
    wire dma_set = (fast || remote) && evt_in.dma_tc;
    wire hs_set = evt_in.hs_toggle && evt_in.handshake_status_en;
    wire fend_set = fast && evt_in.frame_end;
    wire thre_set = tx_empty && !tx_empty_q;
    wire idle_set = tx_idle && !tx_idle_q;

    // Character ticks since last receive access
    wire rx_touch = rd_buf || !rx_has || !fifo_en;
    wire cnt_done = char_cnt_r == IRP_RX_TIMEOUT_CHARS;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && addr_bad;
            if (setup) begin
                prdata_r <= addr_bad ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ien_r <= IRP_RST_IRQ_ENABLE;
            fifo_ctrl_r <= IRP_RST_FIFO_CTRL;
            set_select_r <= IRP_RST_SET_SELECT;
            ir_control_r <= IRP_RST_IR_CONTROL;
            hs_control_r <= IRP_RST_HS_CONTROL;
            scratch_r <= IRP_RST_SCRATCH;
        end else begin
            if (wr_ien) begin
                ien_r <= wbyte;
            end
            if (wr_fifo) begin
                fifo_ctrl_r <= fifo_ctrl_nxt;
            end
            if (wr_sel) begin
                set_select_r <= wbyte;
                if (ctrl_set) begin
                    ir_control_r <= wbyte;
                end
            end
            if (wr_hsc) begin
                hs_control_r <= wbyte;
            end
            if (wr_scr) begin
                scratch_r <= wbyte;
            end
        end
    end

    // One-cycle strobes toward the data path
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tx_data_r <= 8'h00;
            tx_write_r <= 1'b0;
            rx_read_r <= 1'b0;
            line_rd_r <= 1'b0;
            hs_rd_r <= 1'b0;
            rx_rst_r <= 1'b0;
            tx_rst_r <= 1'b0;
        end else begin
            tx_write_r <= wr_buf;
            rx_read_r <= rd_buf;
            line_rd_r <= rd_line;
            hs_rd_r <= rd_hs;
            rx_rst_r <= wr_fifo && fifo_on_nxt && wbyte[IRP_RX_FIFO_RST_BIT];
            tx_rst_r <= wr_fifo && fifo_on_nxt && wbyte[IRP_TX_FIFO_RST_BIT];
            if (wr_buf) begin
                tx_data_r <= wbyte;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            line_err_r <= 1'b0;
            thre_r <= 1'b0;
            timer_flag_r <= 1'b0;
            dma_flag_r <= 1'b0;
            hs_flag_r <= 1'b0;
            fend_r <= 1'b0;
            tx_idle_r <= 1'b0;
            tx_empty_q <= 1'b0;
            tx_idle_q <= 1'b0;
        end else begin
            tx_empty_q <= tx_empty;
            tx_idle_q <= tx_idle;
            line_err_r <= (line_err_r && !rd_line) || line_set;
            thre_r <= (thre_r && !wr_buf && !(rd_status && thre_top)) || thre_set;
            timer_flag_r <= (timer_flag_r && !rd_status) || timer_set;
            dma_flag_r <= (dma_flag_r && !rd_status) || dma_set;
            hs_flag_r <= (hs_flag_r && !rd_hs) || hs_set;
            fend_r <= (fend_r && !rd_status) || fend_set;
            tx_idle_r <= (tx_idle_r && !rd_status) || idle_set;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            char_cnt_r <= 3'h0;
            timeout_r <= 1'b0;
        end else if (rx_touch) begin
            char_cnt_r <= 3'h0;
            timeout_r <= 1'b0;
        end else if (evt_in.char_tick && !cnt_done) begin
            char_cnt_r <= char_cnt_r + 3'h1;
            timeout_r <= (char_cnt_r + 3'h1) == IRP_RX_TIMEOUT_CHARS;
        end
    end

    // DMA routing is only offered in the fast and remote modes
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            irq_r <= 1'b0;
            active_set_r <= 3'd0;
            dma_allowed_r <= 1'b0;
            dma_single_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
            active_set_r <= set_nxt;
            dma_allowed_r <= (fast || remote) && hs_control_r[IRP_DMA_EN_BIT];
            dma_single_r <= cfg_in.dma_channel_swap
                            || (cfg_in.dma_rx_en && !cfg_in.dma_tx_en);
        end
    end

    assign pready_out = pready_r;
    assign prdata_out = prdata_r;
    assign pslverr_out = pslverr_r;
    assign tx_data_out = tx_data_r;
    assign tx_write_out = tx_write_r;
    assign rx_read_out = rx_read_r;
    assign line_status_read_out = line_rd_r;
    assign hs_status_read_out = hs_rd_r;
    assign rx_fifo_reset_out = rx_rst_r;
    assign tx_fifo_reset_out = tx_rst_r;
    assign active_set_out = active_set_r;
    assign ir_control_out = ir_control_r;
    assign hs_control_out = hs_control_r;
    assign fifo_mode_out = fifo_ctrl_r[IRP_FIFO_EN_BIT];
    assign dma_allowed_out = dma_allowed_r;
    assign dma_single_out = dma_single_r;
    assign irq_out = irq_r;

endmodule : irp_set0_regs
`default_nettype wire

// >>> src/irp_pkg.sv
package irp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [2:0] IRP_IDX_BUFFER = 3'h0;
    localparam logic [2:0] IRP_IDX_IRQ_ENABLE = 3'h1;
    localparam logic [2:0] IRP_IDX_STATUS_FIFO = 3'h2;
    localparam logic [2:0] IRP_IDX_SET_SELECT = 3'h3;
    localparam logic [2:0] IRP_IDX_HS_CONTROL = 3'h4;
    localparam logic [2:0] IRP_IDX_LINE_STATUS = 3'h5;
    localparam logic [2:0] IRP_IDX_HS_STATUS = 3'h6;
    localparam logic [2:0] IRP_IDX_SCRATCH = 3'h7;

    // Reset values
    localparam logic [7:0] IRP_RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] IRP_RST_FIFO_CTRL = 8'h00;
    localparam logic [7:0] IRP_RST_SET_SELECT = 8'h00;
    localparam logic [7:0] IRP_RST_IR_CONTROL = 8'h00;
    localparam logic [7:0] IRP_RST_HS_CONTROL = 8'h60;
    localparam logic [7:0] IRP_RST_SCRATCH = 8'h00;

    // Interrupt enable readback masks
    localparam logic [7:0] IRP_IEN_LEGACY_MASK = 8'h07;
    localparam logic [7:0] IRP_IEN_ADV_MASK = 8'hf7;

    // Field positions
    localparam int IRP_FIFO_EN_BIT = 0;
    localparam int IRP_RX_FIFO_RST_BIT = 1;
    localparam int IRP_TX_FIFO_RST_BIT = 2;
    localparam int IRP_DMA_EN_BIT = 2;
    localparam int IRP_SET_HIGH_BIT = 7;

    // Set select codes for sets 2..7
    localparam logic [7:0] IRP_SEL_SET2 = 8'he0;
    localparam logic [7:0] IRP_SEL_SET3 = 8'he4;
    localparam logic [7:0] IRP_SEL_SET4 = 8'he8;
    localparam logic [7:0] IRP_SEL_SET5 = 8'hec;
    localparam logic [7:0] IRP_SEL_SET6 = 8'hf0;
    localparam logic [7:0] IRP_SEL_SET7 = 8'hf4;

    // Advanced sub-mode codes
    localparam logic [2:0] IRP_MODE_MIR_LOW = 3'h1;
    localparam logic [2:0] IRP_MODE_MIR_HIGH = 3'h4;
    localparam logic [2:0] IRP_MODE_FIR = 3'h5;
    localparam logic [2:0] IRP_MODE_REMOTE = 3'h6;

    // Receive-data time-out, in character times
    localparam logic [2:0] IRP_RX_TIMEOUT_CHARS = 3'h4;

    // Threshold tables, 16- and 32-byte FIFO
    localparam logic [5:0] IRP_RX_THR_16 [4] = '{6'd1, 6'd4, 6'd8, 6'd14};
    localparam logic [5:0] IRP_RX_THR_32 [4] = '{6'd1, 6'd4, 6'd16, 6'd26};
    localparam logic [5:0] IRP_TX_THR_16 [4] = '{6'd1, 6'd3, 6'd9, 6'd13};
    localparam logic [5:0] IRP_TX_THR_32 [4] = '{6'd1, 6'd7, 6'd17, 6'd25};

    // Legacy identification codes, bits 3..0
    localparam logic [3:0] IRP_ID_NONE = 4'h1;
    localparam logic [3:0] IRP_ID_LINE = 4'h6;
    localparam logic [3:0] IRP_ID_RX = 4'h4;
    localparam logic [3:0] IRP_ID_TIMEOUT = 4'hc;
    localparam logic [3:0] IRP_ID_TX_EMPTY = 4'h2;

    // Events from the rest of the port, same clock
    typedef struct packed {
        logic line_error;
        logic timer_zero;
        logic timer_loaded;
        logic timer_run;
        logic frame_end;
        logic fsf_at_threshold;
        logic dma_tc;
        logic hs_toggle;
        logic handshake_status_en;
        logic char_tick;
        logic tx_shift_empty;
    } irp_evt_t;

    // Queue levels and data from the transmit/receive path
    typedef struct packed {
        logic [7:0] rx_data;
        logic [5:0] rx_level;
        logic [5:0] tx_level;
        logic fifo32;
        logic [7:0] line_status;
        logic [7:0] handshake_status;
    } irp_path_t;

    typedef struct packed {
        logic dma_tx_en;
        logic dma_rx_en;
        logic dma_channel_swap;
        logic adv_mode;
    } irp_cfg_t;

endpackage : irp_pkg

// >>> verif/irp_set0_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
module irp_set0_regs_props
    import irp_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic pready_out,
    input wire logic [31:0] prdata_out,
    input wire logic pslverr_out,
    input wire irp_cfg_t cfg_in,
    input wire logic [7:0] tx_data_out,
    input wire logic tx_write_out,
    input wire logic rx_read_out,
    input wire logic rx_fifo_reset_out,
    input wire logic [2:0] active_set_out,
    input wire logic fifo_mode_out,
    input wire logic dma_allowed_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    wire logic acc = psel_in && penable_in && pready_out;
    wire logic set0 = active_set_out == 3'h0 && paddr_in[11:5] == 7'h00 && paddr_in[1:0] == 2'h0;
    sequence s_wr(logic [2:0] i);
        acc && pwrite_in && set0 && paddr_in[4:2] == i;
    endsequence
    sequence s_rd(logic [2:0] i);
        acc && !pwrite_in && set0 && paddr_in[4:2] == i;
    endsequence
    sequence s_sel(logic [7:0] v);
        acc && pwrite_in && paddr_in == 12'h00c && pwdata_in[7:0] == v;
    endsequence
    AST_ONE_WAIT: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
        else $error("access not one cycle");
    AST_UNMAPPED: assert property (acc && paddr_in[11:5] != 7'h00 |-> pslverr_out)
        else $error("no error on unmapped");
    AST_SET_SWITCH: assert property (s_sel(IRP_SEL_SET2) |-> ##[1:3] active_set_out == 3'h2)
        else $error("set 2 not reached");
    AST_TX_BYTE: assert property (s_wr(IRP_IDX_BUFFER) |=>
        tx_write_out && tx_data_out == $past(pwdata_in[7:0])) else $error("transmit byte lost");
    AST_RX_STROBE: assert property (s_rd(IRP_IDX_BUFFER) |=> rx_read_out)
        else $error("no receive strobe");
    AST_PIO_ONLY: assert property (!cfg_in.adv_mode [*2] |-> !dma_allowed_out)
        else $error("DMA in legacy mode");
    AST_IEN_READ: assert property (s_rd(IRP_IDX_IRQ_ENABLE) |-> prdata_out[3] == 1'b0 &&
        (cfg_in.adv_mode || prdata_out[7:4] == 4'h0)) else $error("reserved enable bits set");
    AST_LEGACY_STATUS: assert property (s_rd(IRP_IDX_STATUS_FIFO) ##0 !cfg_in.adv_mode |->
        prdata_out[7:6] == {2{fifo_mode_out}} && prdata_out[5:4] == 2'h0)
        else $error("legacy status high bits wrong");
    AST_FIFO_ENABLE: assert property (s_wr(IRP_IDX_STATUS_FIFO) |=>
        fifo_mode_out == $past(pwdata_in[0])) else $error("fifo mode wrong");
    AST_FIFO_RESET: assert property (s_wr(IRP_IDX_STATUS_FIFO) ##0 pwdata_in[1:0] == 2'h3 |=>
        rx_fifo_reset_out) else $error("no receive reset");
endmodule : irp_set0_regs_props
bind irp_set0_regs irp_set0_regs_props irp_set0_regs_props_inst (.clk_in, .reset_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out,
    .cfg_in, .tx_data_out, .tx_write_out, .rx_read_out, .rx_fifo_reset_out, .active_set_out,
    .fifo_mode_out, .dma_allowed_out);
`default_nettype wire

// >>> verif/irp_path_model.sv
`timescale 1ns/10ps
`default_nettype none
module irp_path_model
    import irp_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic push_in,
    input wire logic [7:0] byte_in,
    input wire logic pop_in,
    input wire logic tx_write_in,
    output var irp_path_t path_out
);
    logic [7:0] q [$];
    logic [7:0] last;
    irp_path_t p;
    // Levels trail the strobes by one cycle, as a real queue would
    always @(posedge clk_in) begin
        if (reset_in) begin
            q = {};
            last = 8'h00;
            p = '0;
        end else begin
            if (pop_in && q.size() > 0) last = q.pop_front();
            if (push_in) q.push_back(byte_in);
            if (tx_write_in) p.tx_level = p.tx_level + 6'h01;
        end
        p.rx_level = 6'(q.size());
        // Empty queue shows inverted last byte
        p.rx_data = (q.size() > 0) ? q[0] : ~last;
        path_out <= p;
    end
endmodule : irp_path_model
`default_nettype wire

// >>> verif/irp_set0_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module irp_set0_regs_tb_top
    import irp_pkg::*;
    ;
    logic clk_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h00000000, prdata_out, rdat;
    logic pready_out, pslverr_out, tx_write_out, rx_read_out, fifo_mode_out, rerr, push = 1'b0;
    logic dma_allowed_out, dma_single_out, irq_out, line_status_read_out, tx_fifo_reset_out;
    logic [7:0] tx_data_out, push_byte = 8'h00;
    logic [2:0] active_set_out;
    irp_evt_t evt_in = '0;
    irp_cfg_t cfg_in = '0;
    irp_path_t path_in;
    int mismatches = 0, checked = 0, cycles = 0;

    always #4 clk_in = ~clk_in;

    irp_set0_regs irp_set0_regs_inst (.clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .evt_in, .path_in,
        .cfg_in, .tx_data_out, .tx_write_out, .rx_read_out, .line_status_read_out,
        .hs_status_read_out(), .rx_fifo_reset_out(), .tx_fifo_reset_out, .active_set_out,
        .ir_control_out(), .hs_control_out(), .fifo_mode_out, .dma_allowed_out,
        .dma_single_out, .irq_out);
    irp_path_model irp_path_model_inst (.clk_in(clk_in), .reset_in(reset_in), .push_in(push),
        .byte_in(push_byte), .pop_in(rx_read_out), .tx_write_in(tx_write_out),
        .path_out(path_in));

    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1);
        chk(n, 32'h1);
        rdat = prdata_out;
        rerr = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask : apb

    // Upper data bits are junk
    task wr(input logic [2:0] i, input logic [7:0] d);
        apb(1'b1, {7'h00, i, 2'h0}, {24'h5a5a5a, d});
    endtask : wr

    task rd(input logic [2:0] i, input logic [7:0] e);
        apb(1'b0, {7'h00, i, 2'h0}, 32'h0);
        chk(rdat, {24'h0, e});
    endtask : rd

    task push_rx(input logic [7:0] b);
        push_byte <= b;
        push <= 1'b1;
        @(posedge clk_in);
        push <= 1'b0;
        tick(3);
    endtask : push_rx

    // Bit numbers follow struct order, msb first
    task pulse(input int b);
        evt_in[b] <= 1'b1;
        @(posedge clk_in);
        evt_in[b] <= 1'b0;
        tick(2);
    endtask : pulse

    task t_reset_values;
        rd(IRP_IDX_IRQ_ENABLE, 8'h00);
        rd(IRP_IDX_STATUS_FIFO, 8'h01);
        rd(IRP_IDX_HS_CONTROL, 8'h60);
        rd(IRP_IDX_SET_SELECT, 8'h00);
    endtask : t_reset_values

    task t_enables;
        wr(IRP_IDX_IRQ_ENABLE, 8'hff);
        rd(IRP_IDX_IRQ_ENABLE, 8'h07);
        cfg_in.adv_mode <= 1'b1;
        rd(IRP_IDX_IRQ_ENABLE, 8'hf7);
        cfg_in.adv_mode <= 1'b0;
        wr(IRP_IDX_IRQ_ENABLE, 8'h00);
    endtask : t_enables

    task t_buffer;
        push_rx(8'ha5);
        rd(IRP_IDX_BUFFER, 8'ha5);
        wr(IRP_IDX_BUFFER, 8'h3c);
        chk({24'h0, tx_data_out}, 32'h3c);
        chk({31'h0, tx_write_out}, 32'h1);
    endtask : t_buffer

    task t_legacy_irq;
        push_rx(8'h5e);
        rd(IRP_IDX_STATUS_FIFO, 8'h01);
        wr(IRP_IDX_IRQ_ENABLE, 8'h01);
        tick(2);
        rd(IRP_IDX_STATUS_FIFO, 8'h04);
        chk({31'h0, irq_out}, 32'h1);
        rd(IRP_IDX_BUFFER, 8'h5e);
        tick(3);
        rd(IRP_IDX_STATUS_FIFO, 8'h01);
        chk({31'h0, irq_out}, 32'h0);
    endtask : t_legacy_irq

    task t_timeout;
        wr(IRP_IDX_STATUS_FIFO, 8'hc1);
        push_rx(8'h77);
        rd(IRP_IDX_STATUS_FIFO, 8'hc1);
        repeat (3) pulse(1);
        rd(IRP_IDX_STATUS_FIFO, 8'hc1);
        pulse(1);
        rd(IRP_IDX_STATUS_FIFO, 8'hcc);
        rd(IRP_IDX_BUFFER, 8'h77);
        tick(3);
        rd(IRP_IDX_STATUS_FIFO, 8'hc1);
        wr(IRP_IDX_STATUS_FIFO, 8'h07);
        chk({31'h0, tx_fifo_reset_out}, 32'h1);
        wr(IRP_IDX_STATUS_FIFO, 8'h00);
        rd(IRP_IDX_STATUS_FIFO, 8'h01);
    endtask : t_timeout

    task t_sets;
        logic [7:0] codes [6];
        codes = '{IRP_SEL_SET2, IRP_SEL_SET3, IRP_SEL_SET4, IRP_SEL_SET5, IRP_SEL_SET6,
            IRP_SEL_SET7};
        wr(IRP_IDX_IRQ_ENABLE, 8'h05);
        for (int k = 0; k < 6; k++) begin
            wr(IRP_IDX_SET_SELECT, codes[k]);
            tick(3);
            chk({29'h0, active_set_out}, 32'(k + 2));
            rd(IRP_IDX_IRQ_ENABLE, 8'h00);
        end
        wr(IRP_IDX_SET_SELECT, 8'h80);
        tick(3);
        chk({29'h0, active_set_out}, 32'h1);
        wr(IRP_IDX_SET_SELECT, 8'h00);
        tick(3);
        chk({29'h0, active_set_out}, 32'h0);
        rd(IRP_IDX_IRQ_ENABLE, 8'h05);
        pulse(10);
        rd(IRP_IDX_STATUS_FIFO, 8'h06);
        rd(IRP_IDX_LINE_STATUS, 8'h00);
        chk({31'h0, line_status_read_out}, 32'h1);
        rd(IRP_IDX_STATUS_FIFO, 8'h01);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        wr(IRP_IDX_IRQ_ENABLE, 8'h00);
    endtask : t_sets

    task t_dma;
        for (int k = 0; k < 8; k++) begin
            cfg_in.dma_tx_en <= k[0];
            cfg_in.dma_rx_en <= k[1];
            cfg_in.dma_channel_swap <= k[2];
            tick(2);
            chk({31'h0, dma_single_out}, 32'(k[2] | (k[1] & ~k[0])));
        end
        wr(IRP_IDX_HS_CONTROL, 8'ha4);
        tick(2);
        chk({31'h0, dma_allowed_out}, 32'h0);
        cfg_in.adv_mode <= 1'b1;
        tick(2);
        chk({31'h0, dma_allowed_out}, 32'h1);
    endtask : t_dma

    task t_adv_status;
        logic [7:0] exp_st [4];
        int ev [4];
        exp_st = '{8'h30, 8'ha0, 8'h24, 8'h20};
        ev = '{4, 9, 6, 3};
        evt_in.timer_loaded <= 1'b1;
        evt_in.timer_run <= 1'b1;
        wr(IRP_IDX_IRQ_ENABLE, 8'h90);
        wr(IRP_IDX_STATUS_FIFO, 8'h31);
        rd(IRP_IDX_STATUS_FIFO, 8'h20);
        for (int k = 0; k < 4; k++) begin
            pulse(ev[k]);
            rd(IRP_IDX_STATUS_FIFO, exp_st[k]);
            rd(IRP_IDX_STATUS_FIFO, 8'h20);
        end
        evt_in.fsf_at_threshold <= 1'b1;
        tick(2);
        rd(IRP_IDX_STATUS_FIFO, 8'h60);
        evt_in.fsf_at_threshold <= 1'b0;
        tick(2);
        rd(IRP_IDX_STATUS_FIFO, 8'h20);
    endtask : t_adv_status

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict;
        end
    end

    initial begin
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        t_reset_values;
        t_enables;
        t_buffer;
        t_legacy_irq;
        t_timeout;
        t_sets;
        t_dma;
        t_adv_status;
        give_verdict;
    end
endmodule : irp_set0_regs_tb_top
`default_nettype wire
